// File: sbs_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the
  sampling burst scheduler. Assumes a 25 MHz clock.
*/
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH
`define SBS_CLK_NS      40
`define SBS_TICK_MS     10
`define SBS_TICK_CYC    ((`SBS_TICK_MS * 1000000) / `SBS_CLK_NS)
`define SBS_TPS         7'h64
`define SBS_TS_MS       400
`define SBS_TS_TICKS    (`SBS_TS_MS / `SBS_TICK_MS)
`define SBS_SHORT_TICKS 16'h001E
`define SBS_TSREC_TICKS 16'h0032
`define SBS_PER_MIN     16'h000A
`define SBS_PER_MAX     16'h03E8
`define SBS_HK_LAST     4'h9
`define SBS_A_CTRL      8'h00
`define SBS_A_PERIOD    8'h04
`define SBS_A_DELAY     8'h08
`define SBS_A_BLEN      8'h0C
`define SBS_A_BINT      8'h10
`define SBS_A_WARM      8'h14
`define SBS_A_STAT      8'h18
`define SBS_A_CMD       8'h1C
`define SBS_C_BURST     0
`define SBS_C_PWR       1
`define SBS_C_NV        2
`define SBS_C_MODE0     4
`define SBS_C_MODE1     6
`define SBS_K_START     0
`define SBS_K_STOP      1
`define SBS_K_DEM       2
`define SBS_K_CAL       4
`define SBS_S_REJ       8
`define SBS_S_WARN      9
`define SBS_S_CNT       16
`define SBS_RST_PERIOD  16'h0032
`endif

// File: sbs_pkg.sv
/*
  Types of the sampling burst scheduler.
  Assumes sbs_defines.svh for all numeric constants.
*/
package sbs_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DLY  = 5'h02,
    ST_WARM = 5'h04,
    ST_RUN  = 5'h08,
    ST_BSLP = 5'h10
  } sbs_st_type;
  typedef enum logic [1:0] {
    CH_BB = 2'h0,
    CH_FL = 2'h1,
    CH_TS = 2'h2
  } sbs_chm_type;
  typedef enum logic [1:0] {
    SRC_FRESH = 2'h0,
    SRC_REP   = 2'h1,
    SRC_ZERO  = 2'h2,
    SRC_OFF   = 2'h3
  } sbs_src_type;
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] delay;
    logic [15:0] blen;
    logic [15:0] bint;
    logic [15:0] warm;
    logic        burst;
    logic        pwr;
    logic        nv;
    sbs_chm_type mode0;
    sbs_chm_type mode1;
  } sbs_cfg_type;
  typedef struct packed {
    logic        stb;
    logic        log;
    logic        hk;
    logic [1:0]  dem;
    sbs_src_type [3:0] src;
  } sbs_smp_type;
endpackage

// File: sbs_scheduler.sv
/*
  Sampling burst scheduler: start delay, periodic and burst sampling,
  channel time-share, housekeeping cadence, AXI4-Lite registers.
  Assumes nv_valid/nv_image come from a memory on clk; pins are async.
*/
// Decided for this implementation: the address map and register access over AXI4-Lite.
// Contract
// RULE_01: Sample period is held in 0.01 s ticks and controls sampling.
// RULE_02: Periods from 0.1 s to 10 s accepted; burst mode allows long runs.
// RULE_03: On start, wait start delay seconds, then sample every period.
// RULE_04: In burst mode, sleep once burst length has elapsed.
// RULE_05: In burst mode, restart a burst every burst interval.
// RULE_06: Each burst waits warm-up seconds before its first sample.
// RULE_07: Stop command, switch off or battery exhausted stops sampling.
// RULE_08: Unsupported settings are refused, e.g. burst length over interval.
// RULE_09: Start-on-power-up option starts logging after a cold power-up.
// RULE_10: Each dual channel measures first, second, or time-shares both.
// RULE_11: Time-share switches measurement type every 0.4 seconds.
// RULE_12: A skipped type repeats its latest measured value.
// RULE_13: Period below 0.3 s outputs zero for never-taken measurements.
// RULE_14: Settings causing missing data raise a warning but still apply.
// RULE_15: Host should use periods of at least 0.5 s with time-share.
// RULE_16: Nonvolatile option saves settings across reset and power loss.
// RULE_17: Logged samples are also sent on the serial port.
// RULE_18: Three demand commands each give one unlogged sample.
// RULE_19: Host reads settings back after writing them.
// RULE_20: Host requests identification before proceeding.
// RULE_21: Host search tries all ports at 4800 to 57600 baud.
// RULE_22: Calibration request makes the device send its coefficients.
// RULE_23: One housekeeping record follows every ten primary samples.
// RULE_24: All timing derives from one 10 ms tick and counters.
`timescale 1ns/100ps
`include "sbs_defines.svh"
module sbs_scheduler
  import sbs_pkg::*;
#(
  parameter int TICK_CYC = `SBS_TICK_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        switch_pin,
  input  wire logic        batt_low_pin,
  input  wire logic        nv_valid,
  input  wire sbs_cfg_type nv_image,
  output      sbs_smp_type smp,
  output      logic        sleep,
  output      logic        ts_phase,
  output      logic        warn,
  output      logic        cal_send,
  output      logic        nv_save,
  output      sbs_cfg_type nv_data
);
  typedef struct packed {
    sbs_cfg_type cfg;
    sbs_st_type  st;
    sbs_smp_type smp;
    logic [1:0]  init;
    logic        sw1, sw2, swd, bt1, bt2;
    logic [17:0] tdiv;
    logic        tick;
    logic [6:0]  sub;
    logic [15:0] tcnt, bcnt, pcnt, cnt;
    logic [3:0]  hk;
    logic        hkp;
    logic [1:0]  dmp;
    logic [5:0]  tsc;
    logic        phase;
    logic [1:0]  seen, ever;
    logic        rej, wrn, warn, cal, nvs, slp;
    logic        awrdy, wrdy, awv, wv, bv, arrdy, rv;
    logic [7:0]  awa;
    logic [31:0] wd, rd;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp;
  } sbs_state_type;

  sbs_state_type s, n;

  function automatic logic cfg_ok(sbs_cfg_type c);
    cfg_ok = c.period >= `SBS_PER_MIN && c.period <= `SBS_PER_MAX &&
             (!c.burst || (c.blen <= c.bint && c.bint != 16'h0000));
  endfunction

  function automatic logic miss_risk(sbs_cfg_type c);
    miss_risk = (c.mode0 == CH_TS || c.mode1 == CH_TS) &&
                c.period < `SBS_TSREC_TICKS;
  endfunction

  function automatic sbs_src_type chan_src(sbs_chm_type m, logic q,
      logic [1:0] sn, logic [1:0] ev, logic shrt);
    chan_src = SRC_OFF;
    if (m == CH_TS)
    begin
      if (sn[q])
        chan_src = SRC_FRESH;
      else if (ev[q] && !shrt)
        chan_src = SRC_REP;
      else
        chan_src = SRC_ZERO;
    end
    else if ((m == CH_FL) == q)
      chan_src = SRC_FRESH;
  endfunction

  function automatic logic [31:0] reg_rd(sbs_state_type v, logic [7:0] a);
    reg_rd = 32'h0000_0000;
    case (a)
      `SBS_A_CTRL:
      begin
        reg_rd[`SBS_C_BURST] = v.cfg.burst;
        reg_rd[`SBS_C_PWR] = v.cfg.pwr;
        reg_rd[`SBS_C_NV] = v.cfg.nv;
        reg_rd[`SBS_C_MODE0 +: 2] = v.cfg.mode0;
        reg_rd[`SBS_C_MODE1 +: 2] = v.cfg.mode1;
      end
      `SBS_A_PERIOD: reg_rd[15:0] = v.cfg.period;
      `SBS_A_DELAY:  reg_rd[15:0] = v.cfg.delay;
      `SBS_A_BLEN:   reg_rd[15:0] = v.cfg.blen;
      `SBS_A_BINT:   reg_rd[15:0] = v.cfg.bint;
      `SBS_A_WARM:   reg_rd[15:0] = v.cfg.warm;
      `SBS_A_STAT:
      begin
        reg_rd[4:0] = v.st;
        reg_rd[`SBS_S_REJ] = v.rej;
        reg_rd[`SBS_S_WARN] = v.wrn;
        reg_rd[`SBS_S_CNT +: 16] = v.cnt;
      end
      default: reg_rd = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
                                        logic [3:0] b);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = b[i] ? d[8*i +: 8] : o[8*i +: 8];
  endfunction

  logic        sec, start_ev, stop_ev, wr_do, shrt;
  logic [31:0] wm;
  sbs_cfg_type cand;

  always_comb
  begin
    n = s;
    n.tick = 1'b0;
    n.smp.stb = 1'b0;
    n.warn = 1'b0;
    n.cal = 1'b0;
    n.nvs = 1'b0;
    cand = s.cfg;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    n.sw1 = switch_pin;
    n.sw2 = s.sw1;
    n.swd = s.sw2;
    n.bt1 = batt_low_pin;
    n.bt2 = s.bt1;
    // Restore saved settings, then honour power-up start
    n.init = {s.init[0], 1'b0};
    if (s.init[0] && nv_valid)
      n.cfg = nv_image; // [RULE_16]
    if (s.init[1] && s.cfg.pwr)
      start_ev = 1'b1; // [RULE_09]
    // 10 ms tick and one-second strobe
    if (s.tdiv == 18'(TICK_CYC - 1))
    begin
      n.tdiv = 18'h00000;
      n.tick = 1'b1; // [RULE_24]
    end
    else
      n.tdiv = s.tdiv + 18'h00001;
    sec = s.tick && s.sub == `SBS_TPS - 7'h01;
    if (s.tick)
      n.sub = sec ? 7'h00 : s.sub + 7'h01;
    // AXI4-Lite write channel
    if (s_axi_awvalid && s.awrdy)
    begin
      n.awa = {s_axi_awaddr[7:2], 2'h0};
      n.awv = 1'b1;
    end
    if (s_axi_wvalid && s.wrdy)
    begin
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
      n.wv = 1'b1;
    end
    wr_do = s.awv && s.wv && !s.bv;
    wm = merge(reg_rd(s, s.awa), s.wd, s.ws);
    if (wr_do)
    begin
      n.awv = 1'b0;
      n.wv = 1'b0;
      n.bv = 1'b1;
      n.bresp = 2'h0;
      case (s.awa)
        `SBS_A_CTRL:
        begin
          cand.burst = wm[`SBS_C_BURST];
          cand.pwr = wm[`SBS_C_PWR];
          cand.nv = wm[`SBS_C_NV];
          cand.mode0 = sbs_chm_type'(wm[`SBS_C_MODE0 +: 2]); // [RULE_10]
          cand.mode1 = sbs_chm_type'(wm[`SBS_C_MODE1 +: 2]);
        end
        `SBS_A_PERIOD: cand.period = wm[15:0]; // [RULE_01]
        `SBS_A_DELAY:  cand.delay = wm[15:0];
        `SBS_A_BLEN:   cand.blen = wm[15:0];
        `SBS_A_BINT:   cand.bint = wm[15:0];
        `SBS_A_WARM:   cand.warm = wm[15:0];
        `SBS_A_CMD:
        begin
          start_ev = s.wd[`SBS_K_START];
          stop_ev = s.wd[`SBS_K_STOP];
          if (s.wd[`SBS_K_DEM +: 2] != 2'h0)
            n.dmp = s.wd[`SBS_K_DEM +: 2];
          n.cal = s.wd[`SBS_K_CAL]; // [RULE_22]
        end
        `SBS_A_STAT: n.bresp = 2'h0;
        default: n.bresp = 2'h2;
      endcase
      if (s.awa <= `SBS_A_WARM)
      begin
        n.rej = !cfg_ok(cand);
        if (cfg_ok(cand)) // [RULE_08] [RULE_02]
        begin
          n.cfg = cand;
          n.wrn = miss_risk(cand);
          n.warn = miss_risk(cand); // [RULE_14]
          n.nvs = cand.nv; // [RULE_16]
        end
        else
          n.bresp = 2'h2;
      end
    end
    if (s.bv && s_axi_bready)
      n.bv = 1'b0;
    n.awrdy = !n.awv && !n.bv;
    n.wrdy = !n.wv && !n.bv;
    // AXI4-Lite read channel
    if (s_axi_arvalid && s.arrdy)
    begin
      n.rd = reg_rd(s, {s_axi_araddr[7:2], 2'h0});
      n.rresp = s_axi_araddr[7:5] != 3'h0 ? 2'h2 : 2'h0;
      n.rv = 1'b1;
      n.arrdy = 1'b0;
    end
    if (s.rv && s_axi_rready)
    begin
      n.rv = 1'b0;
      n.arrdy = 1'b1;
    end
    // Start and stop sources
    if (s.sw2 && !s.swd)
      start_ev = 1'b1;
    if ((!s.sw2 && s.swd) || s.bt2)
      stop_ev = 1'b1;
    // Channel time-share phase
    if (s.st != ST_IDLE && s.tick)
    begin
      if (s.tsc == 6'(`SBS_TS_TICKS - 1))
      begin
        n.tsc = 6'h00;
        n.phase = !s.phase; // [RULE_11]
        n.seen[s.phase] = 1'b1;
        n.ever[s.phase] = 1'b1;
      end
      else
        n.tsc = s.tsc + 6'h01;
    end
    if (sec && s.st != ST_IDLE)
    begin
      n.tcnt = s.tcnt + 16'h0001;
      n.bcnt = s.bcnt + 16'h0001;
    end
    shrt = s.cfg.period < `SBS_SHORT_TICKS;
    case (s.st)
      ST_IDLE: n.st = ST_IDLE;
      ST_DLY:
        if (s.tcnt >= s.cfg.delay) // [RULE_03]
        begin
          n.st = s.cfg.burst ? ST_WARM : ST_RUN;
          n.tcnt = 16'h0000;
          n.bcnt = 16'h0000;
          n.pcnt = 16'h0000;
        end
      ST_WARM:
        if (s.bcnt >= s.cfg.blen)
          n.st = ST_BSLP;
        else if (s.tcnt >= s.cfg.warm) // [RULE_06]
        begin
          n.st = ST_RUN;
          n.pcnt = 16'h0000;
        end
      ST_RUN:
      begin
        if (s.cfg.burst && s.bcnt >= s.cfg.blen)
          n.st = ST_BSLP; // [RULE_04]
        else if (s.tick)
        begin
          n.pcnt = (s.pcnt + 16'h0001 >= s.cfg.period) ? 16'h0000
                                                       : s.pcnt + 16'h0001;
          if (s.pcnt == 16'h0000)
          begin
            n.smp.stb = 1'b1;
            n.smp.log = 1'b1; // [RULE_17]
            n.smp.hk = 1'b0;
            n.smp.dem = 2'h0;
            n.smp.src[0] = chan_src(s.cfg.mode0, 1'b0, s.seen, s.ever, shrt);
            n.smp.src[1] = chan_src(s.cfg.mode0, 1'b1, s.seen, s.ever, shrt);
            n.smp.src[2] = chan_src(s.cfg.mode1, 1'b0, s.seen, s.ever, shrt);
            n.smp.src[3] = chan_src(s.cfg.mode1, 1'b1, s.seen, s.ever, shrt);
            n.seen = 2'h0; // [RULE_12] [RULE_13]
            n.cnt = s.cnt + 16'h0001;
            n.hkp = s.hk == `SBS_HK_LAST;
            n.hk = s.hk == `SBS_HK_LAST ? 4'h0 : s.hk + 4'h1;
          end
        end
      end
      ST_BSLP:
        if (s.bcnt >= s.cfg.bint) // [RULE_05]
        begin
          n.st = ST_WARM;
          n.bcnt = 16'h0000;
          n.tcnt = 16'h0000;
        end
      default: n.st = ST_IDLE;
    endcase
    if (s.hkp)
    begin
      n.smp.stb = 1'b1;
      n.smp.log = 1'b1;
      n.smp.hk = 1'b1; // [RULE_23]
      n.smp.dem = 2'h0;
      n.hkp = 1'b0;
    end
    else if (!n.smp.stb && s.dmp != 2'h0)
    begin
      n.smp.stb = 1'b1;
      n.smp.log = 1'b0; // [RULE_18]
      n.smp.hk = 1'b0;
      n.smp.dem = s.dmp;
      n.dmp = 2'h0;
    end
    if (start_ev)
    begin
      n.st = ST_DLY;
      n.tcnt = 16'h0000;
      n.hk = 4'h0;
      n.ever = 2'h0;
      n.seen = 2'h0;
      n.tsc = 6'h00;
      n.sub = 7'h00;
      n.tdiv = 18'h00000;
    end
    if (stop_ev)
    begin
      n.st = ST_IDLE; // [RULE_07]
      n.hkp = 1'b0;
    end
    n.slp = n.st == ST_IDLE || n.st == ST_BSLP;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.cfg.period <= `SBS_RST_PERIOD;
      s.st <= ST_IDLE;
      s.init <= 2'h1;
      s.awrdy <= 1'b1;
      s.wrdy <= 1'b1;
      s.arrdy <= 1'b1;
      s.slp <= 1'b1;
    end
    else
      s <= n;
  end

  assign s_axi_awready = s.awrdy;
  assign s_axi_wready = s.wrdy;
  assign s_axi_bvalid = s.bv;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arrdy;
  assign s_axi_rvalid = s.rv;
  assign s_axi_rdata = s.rd;
  assign s_axi_rresp = s.rresp;
  assign smp = s.smp;
  assign sleep = s.slp;
  assign ts_phase = s.phase;
  assign warn = s.warn;
  assign cal_send = s.cal;
  assign nv_save = s.nvs;
  assign nv_data = s.cfg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_cfg_legal;
    !s.init[0] |-> cfg_ok(s.cfg);
  endproperty
  a_cfg_legal: assert property (p_cfg_legal) // [RULE_08]
    else $error("illegal settings held");
  property p_hk_follow;
    s.smp.stb && s.smp.hk |-> $past(s.smp.stb) && !$past(s.smp.hk);
  endproperty
  a_hk_follow: assert property (p_hk_follow) // [RULE_23]
    else $error("housekeeping not after primary");
  property p_stop;
    stop_ev |=> s.st == ST_IDLE && sleep;
  endproperty
  a_stop: assert property (p_stop) // [RULE_07]
    else $error("stop did not idle");
  property p_demand;
    s.smp.stb && s.smp.dem != 2'h0 |-> !s.smp.log && !s.smp.hk;
  endproperty
  a_demand: assert property (p_demand) // [RULE_18]
    else $error("demand sample logged");
  property p_prim_run;
    s.smp.stb && s.smp.log && !s.smp.hk |-> $past(s.st) == ST_RUN;
  endproperty
  a_prim_run: assert property (p_prim_run) // [RULE_03]
    else $error("sample outside run");
  property p_short_zero;
    s.smp.stb && s.cfg.period < `SBS_SHORT_TICKS && $stable(s.cfg)
      |-> s.smp.src[0] != SRC_REP && s.smp.src[3] != SRC_REP;
  endproperty
  a_short_zero: assert property (p_short_zero) // [RULE_13]
    else $error("repeat at short period");
  property p_warn;
    s.warn |-> s.wrn && miss_risk(s.cfg);
  endproperty
  a_warn: assert property (p_warn) // [RULE_14]
    else $error("warning without risk");
  property p_phase;
    $changed(s.phase)
      |-> $past(s.tick) && $past(s.tsc) == 6'(`SBS_TS_TICKS - 1);
  endproperty
  a_phase: assert property (p_phase) // [RULE_11]
    else $error("phase switch off schedule");
  property p_burst_sleep;
    s.st == ST_RUN && s.cfg.burst && s.bcnt >= s.cfg.blen && !start_ev
      |=> s.st == ST_BSLP;
  endproperty
  a_burst_sleep: assert property (p_burst_sleep) // [RULE_04]
    else $error("burst did not sleep");

  c_run: cover property (s.smp.stb && s.smp.log && !s.smp.hk);
  c_bslp: cover property (s.st == ST_BSLP ##1 s.st == ST_WARM);
  c_dem: cover property (s.smp.stb && s.smp.dem != 2'h0);
  c_warn: cover property (s.warn);
endmodule

// File: sbs_host.sv
/*
  Host side model: AXI4-Lite master offering wr and rd tasks.
  Assumes the scheduler's slave on clk; lag delays bready/rready.
*/
`timescale 1ns/100ps
module sbs_host (
  input  wire logic        clk,
  input  wire logic [2:0]  lag,
  output      logic [7:0]  s_axi_awaddr,
  output      logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output      logic [31:0] s_axi_wdata,
  output      logic [3:0]  s_axi_wstrb,
  output      logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output      logic        s_axi_bready,
  output      logic [7:0]  s_axi_araddr,
  output      logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output      logic        s_axi_rready,
  output      logic        tmo
);
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, tmo} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 400; n++)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (n >= lag)
        s_axi_bready <= 1'b1;
    end
    if (n == 400)
      tmo <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    d = 32'h0;
    r = 2'h3;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 400; n++)
    begin
      @(posedge clk);
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (n >= lag)
        s_axi_rready <= 1'b1;
    end
    if (n == 400)
      tmo <= 1'b1;
  endtask
endmodule

// File: sbs_scheduler_tb.sv
/*
  Self-checking bench of the sampling burst scheduler.
  Assumes sbs_host drives the AXI4-Lite port; TICK_CYC shortened.
*/
`timescale 1ns/100ps
`include "sbs_defines.svh"
module sbs_scheduler_tb
  import sbs_pkg::*;
;
  localparam int TK  = 10;
  localparam int SEC = 100 * TK;
  logic              clk = 1'b0;
  logic              rst_n, tmo, arm, tsp_q = 1'b0;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, dem_k;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, switch_pin, batt_low_pin, nv_valid;
  logic              sleep, ts_phase, warn, cal_send, nv_save, dem_log;
  sbs_cfg_type       nv_image, nv_data;
  sbs_smp_type       smp;
  sbs_src_type [3:0] src0, src_l;
  logic [2:0]        lag;
  logic [31:0]       seed = 32'h28;
  int                fails = 0, tests_run = 0, cyc = 0, n_prim = 0;
  int                n_hk = 0, n_dem = 0, n_nolog = 0, n_warn = 0;
  int                n_cal = 0, n_nvs = 0, n_ts = 0, p_cyc = 0;
  int                p_gap = 0, hk_gap = 0, ts_cyc = 0, ts_gap = 0;

  always #20 clk = ~clk;

  sbs_scheduler #(.TICK_CYC(TK)) DUT (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .switch_pin, .batt_low_pin,
    .nv_valid, .nv_image, .smp, .sleep, .ts_phase, .warn, .cal_send,
    .nv_save, .nv_data
  );
  sbs_host HOST (
    .clk, .lag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tmo
  );

  // Record counters and spacing of outputs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    tsp_q <= ts_phase;
    if (ts_phase != tsp_q)
    begin
      n_ts <= n_ts + 1;
      ts_gap <= cyc - ts_cyc;
      ts_cyc <= cyc;
    end
    if (smp.stb && !smp.hk && smp.dem == 2'h0)
    begin
      n_prim <= n_prim + 1;
      p_gap <= cyc - p_cyc;
      p_cyc <= cyc;
      src_l <= smp.src;
      n_nolog <= n_nolog + int'(!smp.log);
      if (arm)
      begin
        src0 <= smp.src;
        arm <= 1'b0;
      end
    end
    if (smp.stb && smp.hk)
    begin
      n_hk <= n_hk + 1;
      hk_gap <= cyc - p_cyc;
    end
    if (smp.stb && smp.dem != 2'h0)
    begin
      n_dem <= n_dem + 1;
      dem_k <= smp.dem;
      dem_log <= smp.log;
    end
    n_warn <= n_warn + int'(warn);
    n_cal <= n_cal + int'(cal_send);
    n_nvs <= n_nvs + int'(nv_save);
    if (tmo || cyc > 95000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic w(input logic [7:0] a, input logic [31:0] d,
                   input logic [1:0] e);
    logic [1:0] r;
    lag = 3'(xs() % 32'h4);
    HOST.wr(a, d, r);
    chk("bresp", 32'(r), 32'(e));
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    HOST.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", 32'(r), 32'(er));
  endtask

  task automatic wst(input logic [4:0] e, output int c);
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    for (i = 0; i < 1000; i++)
    begin
      HOST.rd(`SBS_A_STAT, d, r);
      if (d[4:0] === e)
        break;
    end
    c = cyc;
    chk("state", 32'(d[4:0]), 32'(e));
    if (d[4:0] !== e)
      end_of_test();
  endtask

  task automatic wcnt(ref int v, input int e, input int b);
    int i;
    for (i = 0; i < b && v < e; i++)
      @(posedge clk);
    if (v < e)
    begin
      chk("count", 32'(v), 32'(e));
      end_of_test();
    end
  endtask

  task automatic rng(input int v, lo, hi);
    chk("timing", 32'(v >= lo && v <= hi), 32'h1);
  endtask

  initial
  begin
    int          p, c0, c, n, k;
    sbs_cfg_type cf;
    rst_n = 1'b0;
    switch_pin = 1'b0;
    batt_low_pin = 1'b0;
    nv_valid = 1'b0;
    nv_image = '0;
    lag = 3'h0;
    arm = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(`SBS_A_PERIOD, `SBS_RST_PERIOD, 2'h0);
    rc(8'h20, 32'h0, 2'h2);
    rc(`SBS_A_STAT, 32'h1, 2'h0);
    w(8'h24, 32'h5, 2'h2);
    w(`SBS_A_PERIOD, `SBS_PER_MIN - 16'h1, 2'h2);
    rc(`SBS_A_STAT, 32'h101, 2'h0);
    w(`SBS_A_PERIOD, `SBS_PER_MAX + 16'h1, 2'h2);
    rc(`SBS_A_PERIOD, `SBS_RST_PERIOD, 2'h0);
    w(`SBS_A_PERIOD, `SBS_PER_MAX, 2'h0);
    repeat (4)
    begin
      p = 32'hA + xs() % 32'h3DF;
      w(`SBS_A_PERIOD, p, 2'h0);
      rc(`SBS_A_PERIOD, p, 2'h0);
    end
    w(`SBS_A_BINT, 32'h1, 2'h0);
    w(`SBS_A_BLEN, 32'h2, 2'h0);
    w(`SBS_A_CTRL, 32'h1, 2'h2);
    p = 32'hA + xs() % 32'hB;
    w(`SBS_A_PERIOD, p, 2'h0);
    w(`SBS_A_DELAY, 32'h1, 2'h0);
    w(`SBS_A_CMD, 32'h1, 2'h0);
    c0 = cyc;
    wcnt(n_prim, 1, 4 * SEC);
    rng(p_cyc - c0, SEC - 10, SEC + 30);
    wcnt(n_prim, 12, 4 * SEC);
    chk("period", p_gap, p * TK);
    chk("hk_gap", hk_gap, 32'h1);
    chk("hk_count", n_hk, 32'h1);
    chk("unlogged", n_nolog, 32'h0);
    for (k = 1; k < 4; k++)
    begin
      n = n_dem;
      w(`SBS_A_CMD, k << 2, 2'h0);
      wcnt(n_dem, n + 1, 50);
      chk("dem_code", 32'(dem_k), k);
      chk("dem_log", 32'(dem_log), 32'h0);
    end
    w(`SBS_A_CMD, 32'h2, 2'h0);
    wst(5'h01, c);
    n = n_prim;
    repeat (3 * p * TK) @(posedge clk);
    chk("stopped", n_prim, n);
    w(`SBS_A_CMD, 32'h10, 2'h0);
    wcnt(n_cal, 1, 50);
    chk("cal", n_cal, 32'h1);
    w(`SBS_A_PERIOD, 32'h14, 2'h0);
    w(`SBS_A_DELAY, 32'h0, 2'h0);
    w(`SBS_A_CTRL, 32'h60, 2'h0);
    wcnt(n_warn, 1, 50);
    chk("warn", n_warn, 32'h1);
    rc(`SBS_A_PERIOD, 32'h14, 2'h0);
    arm <= 1'b1;
    w(`SBS_A_CMD, 32'h1, 2'h0);
    wcnt(n_prim, n_prim + 1, SEC);
    chk("zero", 32'(src0[1]), 32'(SRC_ZERO));
    chk("off", 32'(src0[2]), 32'(SRC_OFF));
    n = n_ts;
    wcnt(n_ts, n + 3, 3 * SEC);
    chk("share", ts_gap, `SBS_TS_TICKS * TK);
    w(`SBS_A_PERIOD, `SBS_TSREC_TICKS, 2'h0);
    wcnt(n_prim, n_prim + 4, 4 * SEC);
    chk("repeat", 32'(src_l[1] != SRC_ZERO), 32'h1);
    chk("fresh", 32'(src_l[3]), 32'(SRC_FRESH));
    chk("warn_off", n_warn, 32'h1);
    batt_low_pin <= 1'b1;
    wst(5'h01, c);
    batt_low_pin <= 1'b0;
    w(`SBS_A_CTRL, 32'h0, 2'h0);
    switch_pin <= 1'b1;
    wst(5'h08, c);
    switch_pin <= 1'b0;
    wst(5'h01, c);
    w(`SBS_A_BINT, 32'h3, 2'h0);
    w(`SBS_A_WARM, 32'h1, 2'h0);
    w(`SBS_A_PERIOD, `SBS_PER_MIN, 2'h0);
    w(`SBS_A_CTRL, 32'h1, 2'h0);
    w(`SBS_A_CMD, 32'h1, 2'h0);
    c0 = cyc;
    wst(5'h08, c);
    rng(c - c0, SEC - 10, SEC + 40);
    wst(5'h10, c);
    rng(c - c0, 2 * SEC - 10, 2 * SEC + 40);
    chk("sleep", 32'(sleep), 32'h1);
    wst(5'h04, c);
    rng(c - c0, 3 * SEC - 10, 3 * SEC + 40);
    w(`SBS_A_CMD, 32'h2, 2'h0);
    wst(5'h01, c);
    w(`SBS_A_CTRL, 32'h4, 2'h0);
    wcnt(n_nvs, 1, 50);
    chk("nv_bit", 32'(nv_data.nv), 32'h1);
    cf = '0;
    cf.period = 16'h1E;
    cf.pwr = 1'b1;
    cf.nv = 1'b1;
    nv_image <= cf;
    nv_valid <= 1'b1;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(`SBS_A_PERIOD, 32'h1E, 2'h0);
    wst(5'h08, c);
    end_of_test();
  end
endmodule
